// file: dv/instruction_exec_subset_bench.sv
// Self-checking bench for the instruction execution subset
`timescale 1ns/1ps
`define check_eq(got, exp) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end

module instruction_exec_subset_bench;
   // One ordinary case: request fields and expected acc, {zero, carry}
   typedef struct packed {
      exec_pkg::op_e op;
      logic [7:0] addr;
      logic [7:0] imm;
      logic [7:0] acc;
      logic [1:0] zc;
   } row_s;

   logic core_clk_in;
   logic rst_in;
   logic req_valid_in;
   logic req_ready_out;
   exec_pkg::instr_s req_in;
   logic push_valid_in;
   logic [12:0] push_pc_in;
   logic irq_pending_in;
   logic wake_in;
   logic flag_load_in;
   exec_pkg::flags_s flag_value_in;
   logic wd_expiry_set_in;
   logic [7:0] acc_out;
   logic [12:0] pc_out;
   exec_pkg::flags_s flags_out;
   logic master_int_en_out;
   logic sys_clk_en_out;
   logic watchdog_clear_out;
   logic int_service_out;
   int fails;
   int n_compared;
   int cyc;
   logic [12:0] pc_exp;

   // Program walked in order; memory results read back by copies
   row_s rows [$] = '{
      '{exec_pkg::OP_COPY_X_TO_W, 8'h00, 8'h3C, 8'h3C, 2'h0},
      '{exec_pkg::OP_COPY_W_TO_M, 8'h10, 8'h00, 8'h3C, 2'h0},
      '{exec_pkg::OP_COPY_X_TO_W, 8'h00, 8'h00, 8'h00, 2'h0},
      '{exec_pkg::OP_COMPL_TO_W, 8'h10, 8'h00, 8'hC3, 2'h0},
      '{exec_pkg::OP_COPY_M_TO_W, 8'h10, 8'h00, 8'h3C, 2'h0},
      '{exec_pkg::OP_ADD1_TO_W, 8'h10, 8'h00, 8'h3D, 2'h0},
      '{exec_pkg::OP_COPY_X_TO_W, 8'h00, 8'hFF, 8'hFF, 2'h0},
      '{exec_pkg::OP_COPY_W_TO_M, 8'h11, 8'h00, 8'hFF, 2'h0},
      '{exec_pkg::OP_ADD1_MEM, 8'h11, 8'h00, 8'hFF, 2'h2},
      '{exec_pkg::OP_COPY_M_TO_W, 8'h11, 8'h00, 8'h00, 2'h2},
      '{exec_pkg::OP_SUB1_TO_W, 8'h11, 8'h00, 8'hFF, 2'h0},
      '{exec_pkg::OP_COPY_X_TO_W, 8'h00, 8'h01, 8'h01, 2'h0},
      '{exec_pkg::OP_COPY_W_TO_M, 8'h12, 8'h00, 8'h01, 2'h0},
      '{exec_pkg::OP_SUB1_MEM, 8'h12, 8'h00, 8'h01, 2'h2},
      '{exec_pkg::OP_COPY_M_TO_W, 8'h12, 8'h00, 8'h00, 2'h2},
      '{exec_pkg::OP_DISJ_X_TO_W, 8'h00, 8'h50, 8'h50, 2'h0},
      '{exec_pkg::OP_COPY_X_TO_W, 8'h00, 8'h00, 8'h00, 2'h0},
      '{exec_pkg::OP_DISJ_M_TO_W, 8'h12, 8'h00, 8'h00, 2'h2},
      '{exec_pkg::OP_DISJ_M_TO_W, 8'h10, 8'h00, 8'h3C, 2'h0},
      '{exec_pkg::OP_DISJ_INTO_M, 8'h12, 8'h00, 8'h3C, 2'h0},
      '{exec_pkg::OP_COPY_X_TO_W, 8'h00, 8'hC0, 8'hC0, 2'h0},
      '{exec_pkg::OP_COPY_M_TO_W, 8'h12, 8'h00, 8'h3C, 2'h0},
      '{exec_pkg::OP_COPY_X_TO_W, 8'h00, 8'h81, 8'h81, 2'h0},
      '{exec_pkg::OP_COPY_W_TO_M, 8'h13, 8'h00, 8'h81, 2'h0},
      '{exec_pkg::OP_ROTL_TO_W, 8'h13, 8'h00, 8'h03, 2'h0},
      '{exec_pkg::OP_ROTL_MEM, 8'h13, 8'h00, 8'h03, 2'h0},
      '{exec_pkg::OP_ROTR_MEM, 8'h13, 8'h00, 8'h03, 2'h0},
      '{exec_pkg::OP_COPY_M_TO_W, 8'h13, 8'h00, 8'h81, 2'h0},
      '{exec_pkg::OP_ROTLC_TO_W, 8'h13, 8'h00, 8'h02, 2'h1},
      '{exec_pkg::OP_ROTLC_MEM, 8'h13, 8'h00, 8'h02, 2'h1},
      '{exec_pkg::OP_COPY_M_TO_W, 8'h13, 8'h00, 8'h03, 2'h1},
      '{exec_pkg::OP_ROTLC_TO_W, 8'h13, 8'h00, 8'h07, 2'h0},
      '{exec_pkg::OP_COPY_X_TO_W, 8'h00, 8'hA0, 8'hA0, 2'h0},
      '{exec_pkg::OP_DECIMAL_ADJ, 8'h14, 8'h00, 8'hA0, 2'h1},
      '{exec_pkg::OP_COPY_M_TO_W, 8'h14, 8'h00, 8'h00, 2'h1},
      '{exec_pkg::OP_COPY_X_TO_W, 8'h00, 8'h7B, 8'h7B, 2'h1},
      '{exec_pkg::OP_DECIMAL_ADJ, 8'h14, 8'h00, 8'h7B, 2'h1},
      '{exec_pkg::OP_COPY_M_TO_W, 8'h14, 8'h00, 8'hE1, 2'h1},
      '{exec_pkg::OP_ROTLC_TO_W, 8'h13, 8'h00, 8'h07, 2'h0},
      '{exec_pkg::OP_COPY_X_TO_W, 8'h00, 8'h7B, 8'h7B, 2'h0},
      '{exec_pkg::OP_DECIMAL_ADJ, 8'h14, 8'h00, 8'h7B, 2'h0},
      '{exec_pkg::OP_COPY_M_TO_W, 8'h14, 8'h00, 8'h81, 2'h0},
      '{exec_pkg::OP_COPY_X_TO_W, 8'h00, 8'h45, 8'h45, 2'h0},
      '{exec_pkg::OP_DECIMAL_ADJ, 8'h15, 8'h00, 8'h45, 2'h0},
      '{exec_pkg::OP_COPY_M_TO_W, 8'h15, 8'h00, 8'h45, 2'h0}
   };

   instr_exec dut_u (
      .core_clk_in, .rst_in, .req_valid_in, .req_ready_out, .req_in,
      .push_valid_in, .push_pc_in, .irq_pending_in, .wake_in,
      .flag_load_in, .flag_value_in, .wd_expiry_set_in, .acc_out,
      .pc_out, .flags_out, .master_int_en_out, .sys_clk_en_out,
      .watchdog_clear_out, .int_service_out
   );

   // Free-running 10 MHz clock
   initial begin
      core_clk_in = 1'h0;
      forever #50 core_clk_in = ~core_clk_in;
   end

   // Counts, verdict and end of run
   task automatic give_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Bounded wait for ready; n is the number of edges waited
   task automatic wait_ready(output int n);
      n = 0;
      while (req_ready_out !== 1'h1) begin
         if (n == 20) begin
            `check_eq(req_ready_out, 1'h1)
            give_verdict();
         end
         @(posedge core_clk_in);
         #1;
         n++;
      end
   endtask

   // One request, held until the taking edge, then released
   task automatic send(input exec_pkg::op_e op, input logic [7:0] a,
                       input logic [7:0] x, input logic [12:0] t);
      int n;
      @(posedge core_clk_in);
      #1;
      wait_ready(n);
      req_in = '{op: op, addr: a, imm: x, target: t};
      req_valid_in = 1'h1;
      @(posedge core_clk_in);
      #1;
      req_valid_in = 1'h0;
   endtask

   // Request plus wait for completion
   task automatic do_op(input exec_pkg::op_e op, input logic [7:0] a,
                        input logic [7:0] x, input logic [12:0] t);
      send(op, a, x, t);
      wait_ready(cyc);
   endtask

   // One-cycle pulse on a strobe input
   task automatic pulse(ref logic s);
      @(posedge core_clk_in);
      #1;
      s = 1'h1;
      @(posedge core_clk_in);
      #1;
      s = 1'h0;
   endtask

   // Main sequence
   initial begin
      fails = 0;
      n_compared = 0;
      rst_in = 1'h1;
      req_valid_in = 1'h0;
      req_in = '0;
      push_valid_in = 1'h0;
      push_pc_in = 13'h0000;
      irq_pending_in = 1'h0;
      wake_in = 1'h0;
      flag_load_in = 1'h0;
      flag_value_in = '0;
      wd_expiry_set_in = 1'h0;
      repeat (12) @(posedge core_clk_in);
      #1;
      rst_in = 1'h0;
      pc_exp = 13'h0000;
      foreach (rows[i]) begin
         do_op(rows[i].op, rows[i].addr, rows[i].imm, 13'h0000);
         pc_exp = pc_exp + 13'h0001;
         `check_eq(acc_out, rows[i].acc)
         `check_eq({flags_out.zero, flags_out.carry}, rows[i].zc)
         `check_eq(pc_out, pc_exp)
      end
      // Reset in mid-run
      rst_in = 1'h1;
      #1;
      `check_eq(acc_out, exec_pkg::ACC_RESET)
      `check_eq(pc_out, exec_pkg::PC_RESET)
      `check_eq(flags_out, exec_pkg::FLAGS_RESET)
      `check_eq({master_int_en_out, sys_clk_en_out}, 2'h1)
      @(posedge core_clk_in);
      #1;
      rst_in = 1'h0;
      // Two idle instructions back to back
      @(posedge core_clk_in);
      #1;
      req_in = '{op: exec_pkg::OP_IDLE_INSTR, default: '0};
      req_valid_in = 1'h1;
      repeat (2) @(posedge core_clk_in);
      #1;
      req_valid_in = 1'h0;
      `check_eq(pc_out, 13'h0002)
      `check_eq({acc_out, flags_out}, 13'h0000)
      // Branch
      do_op(exec_pkg::OP_BRANCH, 8'h00, 8'h00, 13'h1ABC);
      `check_eq(pc_out, 13'h1ABC)
      `check_eq(cyc, 1)
      `check_eq(flags_out, exec_pkg::FLAGS_RESET)
      // Returns
      push_pc_in = 13'h0123;
      pulse(push_valid_in);
      do_op(exec_pkg::OP_SUB_EXIT, 8'h00, 8'h00, 13'h0000);
      `check_eq(pc_out, 13'h0124)
      `check_eq(cyc, 1)
      push_pc_in = 13'h0200;
      pulse(push_valid_in);
      do_op(exec_pkg::OP_SUB_EXIT_X, 8'h00, 8'h5A, 13'h0000);
      `check_eq({pc_out, acc_out}, 21'h02015A)
      `check_eq(flags_out, exec_pkg::FLAGS_RESET)
      push_pc_in = 13'h0400;
      pulse(push_valid_in);
      irq_pending_in = 1'h1;
      do_op(exec_pkg::OP_INT_EXIT, 8'h00, 8'h00, 13'h0000);
      irq_pending_in = 1'h0;
      `check_eq(pc_out, exec_pkg::INT_VECTOR)
      `check_eq({int_service_out, master_int_en_out}, 2'h2)
      do_op(exec_pkg::OP_INT_EXIT, 8'h00, 8'h00, 13'h0000);
      `check_eq({pc_out, master_int_en_out}, 14'h0803)
      // Decimal adjust driven by the half carry alone
      flag_value_in = '{half_carry: 1'h1, default: 1'h0};
      pulse(flag_load_in);
      do_op(exec_pkg::OP_COPY_X_TO_W, 8'h00, 8'h32, 13'h0000);
      do_op(exec_pkg::OP_DECIMAL_ADJ, 8'h16, 8'h00, 13'h0000);
      do_op(exec_pkg::OP_COPY_M_TO_W, 8'h16, 8'h00, 13'h0000);
      `check_eq(acc_out, 8'h38)
      `check_eq({flags_out.half_carry, flags_out.carry}, 2'h2)
      // Power down with the expiry flag set beforehand
      pulse(wd_expiry_set_in);
      `check_eq(flags_out.wd_expiry, 1'h1)
      send(exec_pkg::OP_POWER_DOWN, 8'h00, 8'h00, 13'h0000);
      `check_eq(watchdog_clear_out, 1'h1)
      `check_eq({flags_out.power_down, flags_out.wd_expiry}, 2'h2)
      `check_eq({sys_clk_en_out, req_ready_out}, 2'h0)
      repeat (4) @(posedge core_clk_in);
      #1;
      `check_eq({req_ready_out, watchdog_clear_out}, 2'h0)
      `check_eq(acc_out, 8'h38)
      wake_in = 1'h1;
      wait_ready(cyc);
      wake_in = 1'h0;
      `check_eq(sys_clk_en_out, 1'h1)
      do_op(exec_pkg::OP_COPY_M_TO_W, 8'h13, 8'h00, 13'h0000);
      `check_eq(acc_out, 8'h03)
      give_verdict();
   end
endmodule

// file: rtl/data_ram.sv
// Data memory with registered read port
`timescale 1ns/1ps
module data_ram #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic rd_en_in,
   input wire logic [AW-1:0] rd_addr_in,
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [DW-1:0] wr_data_in,
   output logic [DW-1:0] rd_data_out
);
   logic [DW-1:0] mem_q [2**AW]; // Storage, kept over power down
   logic [DW-1:0] rd_q;          // Read data register

   // Write port
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
   end

   // Registered read
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_q <= '0;
      end else if (rd_en_in) begin
         rd_q <= mem_q[rd_addr_in];
      end
   end

   assign rd_data_out = rd_q;
endmodule

// file: rtl/exec_pkg.sv
// Shared constants and types for the instruction execution subset
package exec_pkg;
   localparam int DATA_W = 8;           // Operand width
   localparam int ADDR_W = 8;           // Data memory address width
   localparam int PC_W = 13;            // Program counter width
   localparam int STACK_DEPTH = 8;      // Return stack levels
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [12:0] PC_RESET = 13'h0000;
   localparam logic [12:0] PC_ONE = 13'h0001;
   localparam logic [12:0] INT_VECTOR = 13'h0004;
   localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
   localparam logic [3:0] BCD_FIX = 4'h6;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   localparam logic INT_EN_RESET = 1'b0;
   localparam logic CLK_EN_RESET = 1'b1;

   // Operations carried out by this block
   typedef enum logic [4:0] {
      OP_IDLE_INSTR = 5'b00000,
      OP_COMPL_TO_W = 5'b00001,
      OP_DECIMAL_ADJ = 5'b00010,
      OP_SUB1_MEM = 5'b00011,
      OP_SUB1_TO_W = 5'b00100,
      OP_ADD1_MEM = 5'b00101,
      OP_ADD1_TO_W = 5'b00110,
      OP_POWER_DOWN = 5'b00111,
      OP_BRANCH = 5'b01000,
      OP_COPY_M_TO_W = 5'b01001,
      OP_COPY_X_TO_W = 5'b01010,
      OP_COPY_W_TO_M = 5'b01011,
      OP_DISJ_M_TO_W = 5'b01100,
      OP_DISJ_X_TO_W = 5'b01101,
      OP_DISJ_INTO_M = 5'b01110,
      OP_SUB_EXIT = 5'b01111,
      OP_SUB_EXIT_X = 5'b10000,
      OP_INT_EXIT = 5'b10001,
      OP_ROTL_MEM = 5'b10010,
      OP_ROTL_TO_W = 5'b10011,
      OP_ROTLC_MEM = 5'b10100,
      OP_ROTLC_TO_W = 5'b10101,
      OP_ROTR_MEM = 5'b10110
   } op_e;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_BRANCH = 2'b10,
      ST_SLEEP = 2'b11
   } state_e;

   // One decoded instruction
   typedef struct packed {
      op_e op;
      logic [7:0] addr;
      logic [7:0] imm;
      logic [12:0] target;
   } instr_s;

   // Status flags
   typedef struct packed {
      logic zero;
      logic carry;
      logic half_carry;
      logic power_down;
      logic wd_expiry;
   } flags_s;

   localparam flags_s FLAGS_RESET = '0;
endpackage

// file: rtl/instr_exec.sv
// Execution unit for an 8-bit microcontroller instruction subset
`timescale 1ns/1ps
// What this block does
// - Complement memory into accumulator, zero flag only
// - Low nibble above 9 or half carry: add 6
// - High nibble above 9 or carry: add 6
// - Decimal adjust writes memory, only carry changes
// - Subtract one, to memory or accumulator, zero
// - Add one, to memory or accumulator, zero
// - Power down halts execution, stops clock
// - Power down clears watchdog, sets flag, clears expiry unless an expiry set comes in the same cycle
// - Branch loads target in two cycles, no flags
// - Copies between memory, immediate, accumulator, no flags
// - OR into accumulator or memory, zero only
// - Idle instruction changes nothing, proceeds onward
// - Subroutine exit pops counter, optionally loads immediate
// - Interrupt exit pops counter, sets master enable if no interrupt is pending
// - Pending interrupt served before resuming main program
// - Plain rotate left, bit 7 to 0
// - Rotate left through carry, carry only
// - Plain rotate right in memory, no flags
// - Accumulator forms leave source memory unchanged
// - Counter-changing instructions take two cycles
// - Stack entry is caller counter plus one; interrupt service pushes the popped address back unchanged
module instr_exec (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire exec_pkg::instr_s req_in,
   input wire logic push_valid_in,
   input wire logic [12:0] push_pc_in,
   input wire logic irq_pending_in,
   input wire logic wake_in,
   input wire logic flag_load_in,
   input wire exec_pkg::flags_s flag_value_in,
   input wire logic wd_expiry_set_in,
   output logic [7:0] acc_out,
   output logic [12:0] pc_out,
   output exec_pkg::flags_s flags_out,
   output logic master_int_en_out,
   output logic sys_clk_en_out,
   output logic watchdog_clear_out,
   output logic int_service_out
);
   exec_pkg::state_e st_q, st_d;  // Sequencer state
   exec_pkg::instr_s cur_q;       // Instruction in flight
   exec_pkg::flags_s flg_q, flg_d; // Status flags
   logic [7:0] acc_q;             // Accumulator
   logic [12:0] pc_q, pc_d;       // Program counter
   logic int_en_q;                // Master interrupt enable
   logic clk_en_q;                // System clock enable
   logic wdog_clr_q;              // Watchdog clear pulse
   logic svc_q;                   // Interrupt service pulse
   logic wake_s1_q, wake_s2_q;    // Wake pin synchroniser
   // Execute stage result and steering
   logic [7:0] res;
   logic wr_mem, wr_acc, upd_z, upd_c, c_new;
   // Memory and stack data
   logic [7:0] m;                 // Addressed memory byte
   logic [12:0] stk_top;          // Popped return address
   // Handshake and state decode
   wire idle = st_q == exec_pkg::ST_IDLE;
   wire accept = req_valid_in & idle;
   wire is_exec = st_q == exec_pkg::ST_EXEC;
   wire is_br = st_q == exec_pkg::ST_BRANCH;
   wire exec_pkg::op_e xop = cur_q.op;
   wire exec_pkg::op_e aop = req_in.op;
   // Decode of the request being taken
   wire a_pop = (aop == exec_pkg::OP_SUB_EXIT) |
                (aop == exec_pkg::OP_SUB_EXIT_X) |
                (aop == exec_pkg::OP_INT_EXIT);
   wire a_br = a_pop | (aop == exec_pkg::OP_BRANCH);
   wire a_halt = aop == exec_pkg::OP_POWER_DOWN;
   wire a_idle = aop == exec_pkg::OP_IDLE_INSTR;
   wire take_halt = accept & a_halt;
   wire take_idle = accept & a_idle;
   // Decimal adjust correction, from accumulator and flags
   wire lo_fix = (acc_q[3:0] > exec_pkg::BCD_MAX_DIGIT) |
                 flg_q.half_carry;
   wire hi_fix = (acc_q[7:4] > exec_pkg::BCD_MAX_DIGIT) |
                 flg_q.carry;
   wire [3:0] corr_lo = lo_fix ? exec_pkg::BCD_FIX : exec_pkg::NIBBLE_ZERO;
   wire [3:0] corr_hi = hi_fix ? exec_pkg::BCD_FIX : exec_pkg::NIBBLE_ZERO;
   wire [8:0] adj_sum = {1'b0, acc_q} + {1'b0, corr_hi, corr_lo};
   wire adj_carry = hi_fix | adj_sum[8];
   // Return and interrupt service steering
   wire int_exit_br = is_br & (xop == exec_pkg::OP_INT_EXIT);
   wire svc_take = int_exit_br & irq_pending_in;
   wire [12:0] br_pc = (xop == exec_pkg::OP_BRANCH) ? cur_q.target
                                                    : stk_top;
   wire stk_push = svc_take | push_valid_in;
   wire [12:0] stk_data = svc_take ? stk_top
                                   : push_pc_in + exec_pkg::PC_ONE;
   wire mem_we = is_exec & wr_mem;
   data_ram #(.AW(exec_pkg::ADDR_W), .DW(exec_pkg::DATA_W)) u_ram (
      .clk_in(core_clk_in),
      .rst_in(rst_in),
      .rd_en_in(accept),
      .rd_addr_in(req_in.addr),
      .wr_en_in(mem_we),
      .wr_addr_in(cur_q.addr),
      .wr_data_in(res),
      .rd_data_out(m)
   );
   return_stack #(.DEPTH(exec_pkg::STACK_DEPTH), .W(exec_pkg::PC_W)) u_stack (
      .clk_in(core_clk_in),
      .rst_in(rst_in),
      .push_in(stk_push),
      .push_data_in(stk_data),
      .pop_in(accept & a_pop),
      .top_out(stk_top)
   );

   // Execute stage datapath, 8-bit wrapping arithmetic
   always_comb begin
      res = exec_pkg::BYTE_ZERO;
      wr_mem = 1'b0;
      wr_acc = 1'b0;
      upd_z = 1'b0;
      upd_c = 1'b0;
      c_new = flg_q.carry;
      case (xop)
         exec_pkg::OP_COMPL_TO_W: begin
            res = ~m;
            wr_acc = 1'b1;
            upd_z = 1'b1;
         end
         exec_pkg::OP_DECIMAL_ADJ: begin
            res = adj_sum[7:0];
            wr_mem = 1'b1;
            upd_c = 1'b1;
            c_new = adj_carry;
         end
         exec_pkg::OP_SUB1_MEM, exec_pkg::OP_SUB1_TO_W: begin
            res = m - exec_pkg::BYTE_ONE;
            wr_mem = xop == exec_pkg::OP_SUB1_MEM;
            wr_acc = xop == exec_pkg::OP_SUB1_TO_W;
            upd_z = 1'b1;
         end
         exec_pkg::OP_ADD1_MEM, exec_pkg::OP_ADD1_TO_W: begin
            res = m + exec_pkg::BYTE_ONE;
            wr_mem = xop == exec_pkg::OP_ADD1_MEM;
            wr_acc = xop == exec_pkg::OP_ADD1_TO_W;
            upd_z = 1'b1;
         end
         exec_pkg::OP_COPY_M_TO_W: begin
            res = m;
            wr_acc = 1'b1;
         end
         exec_pkg::OP_COPY_X_TO_W: begin
            res = cur_q.imm;
            wr_acc = 1'b1;
         end
         exec_pkg::OP_COPY_W_TO_M: begin
            res = acc_q;
            wr_mem = 1'b1;
         end
         exec_pkg::OP_DISJ_M_TO_W, exec_pkg::OP_DISJ_INTO_M: begin
            res = acc_q | m;
            wr_mem = xop == exec_pkg::OP_DISJ_INTO_M;
            wr_acc = xop == exec_pkg::OP_DISJ_M_TO_W;
            upd_z = 1'b1;
         end
         exec_pkg::OP_DISJ_X_TO_W: begin
            res = acc_q | cur_q.imm;
            wr_acc = 1'b1;
            upd_z = 1'b1;
         end
         exec_pkg::OP_ROTL_MEM, exec_pkg::OP_ROTL_TO_W: begin
            res = {m[6:0], m[7]};
            wr_mem = xop == exec_pkg::OP_ROTL_MEM;
            wr_acc = xop == exec_pkg::OP_ROTL_TO_W;
         end
         exec_pkg::OP_ROTLC_MEM, exec_pkg::OP_ROTLC_TO_W: begin
            res = {m[6:0], flg_q.carry};
            wr_mem = xop == exec_pkg::OP_ROTLC_MEM;
            wr_acc = xop == exec_pkg::OP_ROTLC_TO_W;
            upd_c = 1'b1;
            c_new = m[7];
         end
         exec_pkg::OP_ROTR_MEM: begin
            res = {m[0], m[7:1]};
            wr_mem = 1'b1;
         end
         default: res = exec_pkg::BYTE_ZERO;
      endcase
   end

   // Next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         exec_pkg::ST_IDLE: begin
            if (take_halt) begin
               st_d = exec_pkg::ST_SLEEP;
            end else if (accept & a_br) begin
               st_d = exec_pkg::ST_BRANCH;
            end else if (accept & !a_idle) begin
               st_d = exec_pkg::ST_EXEC;
            end
         end
         exec_pkg::ST_EXEC: st_d = exec_pkg::ST_IDLE;
         exec_pkg::ST_BRANCH: st_d = exec_pkg::ST_IDLE;
         exec_pkg::ST_SLEEP: begin
            if (wake_s2_q) begin
               st_d = exec_pkg::ST_IDLE;
            end
         end
         default: st_d = exec_pkg::ST_IDLE;
      endcase
   end

   // Next flags: outside load, then execute updates, then watchdog
   always_comb begin
      flg_d = flg_q;
      if (flag_load_in) begin
         flg_d = flag_value_in;
      end
      if (is_exec & upd_z) begin
         flg_d.zero = res == exec_pkg::BYTE_ZERO;
      end
      if (is_exec & upd_c) begin
         flg_d.carry = c_new;
      end
      if (take_halt) begin
         flg_d.power_down = 1'b1;
         flg_d.wd_expiry = 1'b0;
      end
      if (wd_expiry_set_in) begin
         flg_d.wd_expiry = 1'b1;  // Set wins over clear
      end
   end

   // Next program counter
   always_comb begin
      pc_d = pc_q;
      if (svc_take) begin
         pc_d = exec_pkg::INT_VECTOR;
      end else if (is_br) begin
         pc_d = br_pc;
      end else if (is_exec | take_halt | take_idle) begin
         pc_d = pc_q + exec_pkg::PC_ONE;
      end
   end

   // Sequencer and instruction latch
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= exec_pkg::ST_IDLE;
         cur_q <= '0;
      end else begin
         st_q <= st_d;
         if (accept) begin
            cur_q <= req_in;
         end
      end
   end

   // Accumulator
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         acc_q <= exec_pkg::ACC_RESET;
      end else if (is_exec & wr_acc) begin
         acc_q <= res;
      end else if (is_br & (xop == exec_pkg::OP_SUB_EXIT_X)) begin
         acc_q <= cur_q.imm;
      end
   end

   // Flags and program counter
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         flg_q <= exec_pkg::FLAGS_RESET;
         pc_q <= exec_pkg::PC_RESET;
      end else begin
         flg_q <= flg_d;
         pc_q <= pc_d;
      end
   end

   // Enables, pulses and wake pin synchroniser
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         clk_en_q <= exec_pkg::CLK_EN_RESET;
         int_en_q <= exec_pkg::INT_EN_RESET;
         wdog_clr_q <= 1'b0;
         svc_q <= 1'b0;
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
      end else begin
         clk_en_q <= st_d != exec_pkg::ST_SLEEP;
         wdog_clr_q <= take_halt;
         svc_q <= svc_take;
         wake_s1_q <= wake_in;     // First flop, read only by the second
         wake_s2_q <= wake_s1_q;
         if (int_exit_br) begin
            int_en_q <= !irq_pending_in; // Held off if serviced
         end
      end
   end

   assign req_ready_out = idle;
   assign acc_out = acc_q;
   assign pc_out = pc_q;
   assign flags_out = flg_q;
   assign master_int_en_out = int_en_q;
   assign sys_clk_en_out = clk_en_q;
   assign watchdog_clear_out = wdog_clr_q;
   assign int_service_out = svc_q;

   // Checks on the executed behaviour
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   sequence s_take(exec_pkg::op_e o);
      accept && (aop == o);
   endsequence
   a_compl_acc: assert property (
      is_exec && xop == exec_pkg::OP_COMPL_TO_W |->
      !mem_we ##1 acc_q == ~$past(m) &&
      flg_q.carry == $past(flg_q.carry))
      else $error("complement result wrong");
   a_bcd_adjust: assert property (
      is_exec && xop == exec_pkg::OP_DECIMAL_ADJ |->
      mem_we && res == acc_q
      + (((acc_q[3:0] > 4'h9) || flg_q.half_carry) ? 8'h06 : 8'h00)
      + (((acc_q[7:4] > 4'h9) || flg_q.carry) ? 8'h60 : 8'h00)
      ##1 $stable(acc_q) && $stable(flg_q.zero))
      else $error("decimal adjust wrong");
   a_sub_one_zero: assert property (
      is_exec && xop == exec_pkg::OP_SUB1_MEM |->
      mem_we && res == m - 8'h01 ##1
      flg_q.zero == ($past(m) == 8'h01))
      else $error("subtract one or zero flag wrong");
   a_add_one_acc: assert property (
      is_exec && xop == exec_pkg::OP_ADD1_TO_W |->
      !mem_we ##1 acc_q == $past(m) + 8'h01)
      else $error("add one to accumulator wrong");
   a_power_down: assert property (
      s_take(exec_pkg::OP_POWER_DOWN) |=>
      flg_q.power_down && watchdog_clear_out && !sys_clk_en_out &&
      !req_ready_out ##1 !watchdog_clear_out)
      else $error("power down entry wrong");
   a_branch_two: assert property (
      s_take(exec_pkg::OP_BRANCH) |=> !req_ready_out ##1
      req_ready_out && pc_q == $past(req_in.target, 2))
      else $error("branch timing or target wrong");
   a_int_exit_en: assert property (
      int_exit_br && !irq_pending_in |=>
      master_int_en_out && pc_q == $past(stk_top))
      else $error("interrupt exit wrong");
   a_pending_first: assert property (
      int_exit_br && irq_pending_in |=>
      int_service_out && pc_q == exec_pkg::INT_VECTOR &&
      !master_int_en_out)
      else $error("pending interrupt not served first");
   a_rotl_carry: assert property (
      is_exec && xop == exec_pkg::OP_ROTLC_TO_W |->
      !mem_we ##1 acc_q == {$past(m[6:0]), $past(flg_q.carry)} &&
      flg_q.carry == $past(m[7]))
      else $error("rotate through carry wrong");
   a_idle_instr: assert property (
      accept && aop == exec_pkg::OP_IDLE_INSTR && !flag_load_in &&
      !wd_expiry_set_in |=> $stable(acc_q) && $stable(flg_q) &&
      pc_q == $past(pc_q) + 13'h0001)
      else $error("idle instruction changed state");
endmodule

// file: rtl/return_stack.sv
// Circular return address stack with registered top read
`timescale 1ns/1ps
module return_stack #(
   parameter int DEPTH = 8,
   parameter int W = 13
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic push_in,
   input wire logic [W-1:0] push_data_in,
   input wire logic pop_in,
   output logic [W-1:0] top_out
);
   localparam int PTR_W = $clog2(DEPTH);
   logic [W-1:0] ent_q [DEPTH];  // Stack entries
   logic [PTR_W-1:0] sp_q;       // Next free slot
   logic [W-1:0] top_q;          // Popped value
   wire [PTR_W-1:0] sp_dn = sp_q - 1'b1; // Slot of the top entry

   // Entry writes
   always_ff @(posedge clk_in) begin
      if (push_in) begin
         ent_q[sp_q] <= push_data_in;
      end
   end

   // Pointer and popped value
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sp_q <= '0;
         top_q <= '0;
      end else if (pop_in) begin
         top_q <= ent_q[sp_dn];
         sp_q <= sp_dn;
      end else if (push_in) begin
         sp_q <= sp_q + 1'b1;
      end
   end

   assign top_out = top_q;
endmodule
